// ### logic/cgs_pkg.sv
package cgs_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_STANDBY     = 8'h00;
  localparam logic [7:0] ADDR_GEAR        = 8'h04;
  localparam logic [7:0] ADDR_NOISE       = 8'h08;
  localparam logic [7:0] ADDR_KEY_ONE     = 8'h0C;
  localparam logic [7:0] ADDR_KEY_TWO     = 8'h10;
  localparam logic [7:0] ADDR_IDLE_EN     = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;
  localparam logic [7:0] ADDR_PROT_EXT    = 8'h1C;
  // ==========================================================================
  // Field positions
  localparam int WARMUP_LSB   = 4;
  localparam int HALTM_LSB    = 2;
  localparam int EXT_CLOCK_IN_BIT    = 2;
  localparam int HFDRV_BIT    = 1;
  localparam int LFDRV_BIT    = 0;
  localparam int PROTECT_BIT  = 7;
  // ==========================================================================
  // Reset values
  localparam logic [2:0] GEAR_RST    = 3'h4;
  localparam logic [1:0] WARMUP_RST  = 2'h2;
  localparam logic [1:0] HALTM_RST   = 2'h3;
  localparam logic [4:0] IDLE_EN_RST = 5'h00;
  // ==========================================================================
  // Keys and codes
  localparam logic [7:0] KEY_A = 8'h5A;
  localparam logic [7:0] KEY_B = 8'hA5;
  localparam logic [1:0] HALT_STOP  = 2'h1;
  localparam logic [1:0] HALT_DEEP  = 2'h2;
  localparam logic [1:0] HALT_LIGHT = 2'h3;
  localparam logic [1:0] WU_8  = 2'h1;
  localparam logic [1:0] WU_14 = 2'h2;
  localparam logic [1:0] WU_16 = 2'h3;
  localparam int WU_8_CYC  = 256;
  localparam int WU_14_CYC = 16384;
  localparam int WU_16_CYC = 65536;
  localparam int HOLD_WIN_CYC = 3;
  // Interrupt source bit positions in the wake bus
  localparam int SRC_EXT   = 0;
  localparam int SRC_KEY   = 1;
  localparam int SRC_CLOCK = 2;
  localparam int SRC_ALARM = 3;
  localparam int SRC_WDT   = 4;
  localparam int SRC_PERI  = 5;
  localparam int SRC_NUM   = 6;
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_LIGHT = 4'h2,
    ST_DEEP  = 4'h4,
    ST_STOP  = 4'h8
  } cgs_state_e;
  typedef enum logic [2:0] {
    KS_IDLE = 3'h1,
    KS_K1A  = 3'h2,
    KS_K1B  = 3'h4
  } cgs_key_e;
endpackage : cgs_pkg

// ### logic/cgs_clock_standby.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cgs_clock_standby
  import cgs_pkg::*;
#(
  parameter int WU8  = WU_8_CYC,
  parameter int WU14 = WU_14_CYC,
  parameter int WU16 = WU_16_CYC
) (
  input  wire logic             ref_clk,       // Oscillator clock
  input  wire logic             rst,           // Async reset, high
  input  wire logic             psel,          // APB select
  input  wire logic             penable,       // APB enable
  input  wire logic             pwrite,        // APB direction
  input  wire logic [7:0]       paddr,         // APB address
  input  wire logic [31:0]      pwdata,        // APB write data
  output logic      [31:0]      prdata,        // APB read data
  output logic                  pready,        // APB ready
  output logic                  pslverr,       // APB error
  input  wire logic             haltReq,       // Halt instruction pulse
  input  wire logic [SRC_NUM-1:0] irqReq,      // Interrupt requests
  input  wire logic [SRC_NUM*3-1:0] irqLevel,  // Levels, 3 bits each
  input  wire logic             nmiReq,        // Non-maskable request
  input  wire logic [2:0]       irqMaskLevel,  // CPU mask level
  input  wire logic             protExtWrite,  // External protected write
  output logic                  fastClkEn,     // Fast clock enable pulse
  output logic                  cpuClkEn,      // CPU clock gate
  output logic                  periClkEn,     // Peripheral gate, on in run and light idle
  output logic      [4:0]       idleRunEn,     // Per-peripheral run gate
  output logic                  rtcClkEn,      // Clock and alarm gate
  output logic                  hfOscEn,       // Oscillator run
  output logic                  hfOscDrive,    // Oscillator drive
  output logic                  lfOscDrive,    // Low osc drive
  output logic                  extClockIn,    // External clock mode
  output logic                  oscOutPin,     // Oscillator output pin
  output logic                  portHold,      // Hold port pins
  output logic                  wakeService,   // Wake and service pulse
  output logic                  wakeResume,    // Wake without service pulse
  output logic                  protViolIrq    // Protection violation pulse
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  gearSel;
    logic [2:0]  gearAct;
    logic        gearPend;
    logic [16:0] wuCnt;
    logic [1:0]  warmupSel;
    logic [1:0]  haltSel;
    logic        hfDrv;
    logic        lfDrv;
    logic        ext_clock_in;
    logic        protect;
    logic [4:0]  idleEn;
    cgs_key_e    keySt;
    logic        keyFirst;
    cgs_state_e  st;
    logic [1:0]  entCnt;
    logic        heldPend;
    logic [SRC_NUM-1:0] heldSrc;
    logic [4:0]  divCnt;
    logic        fastEn;
    logic        wakeSvc;
    logic        wakeRes;
    logic        viol;
  } cgs_state_s;
  cgs_state_s cur_r;
  cgs_state_s cur_nxt;
  logic [16:0] wuLen;
  logic [4:0]  divMax;
  logic        acc;
  logic        wr;
  logic        protHit;
  logic        wrOk;
  logic [SRC_NUM-1:0] okLvl;
  logic [SRC_NUM-1:0] canWake;
  logic        svc;
  logic        res;
  logic        svcNew;
  logic        resNew;
  logic        gearWr;
  logic [SRC_NUM-1:0] freshReq;
  // ==========================================================================
  // Per-source level compare
  genvar gi;
  generate
    for (gi = 0; gi < SRC_NUM; gi++) begin : g_lvl
      assign okLvl[gi] = irqReq[gi] && (irqLevel[gi*3 +: 3] >= irqMaskLevel);
      assign freshReq[gi] = irqReq[gi] && !cur_r.heldSrc[gi];
    end
  endgenerate
  // ==========================================================================
  // Combinational helpers
  always_comb begin
    unique case (cur_r.warmupSel)
      WU_8:    wuLen = 17'(WU8);
      WU_14:   wuLen = 17'(WU14);
      WU_16:   wuLen = 17'(WU16);
      default: wuLen = 17'(WU8);
    endcase
    unique case (cur_r.gearAct)
      3'h0:    divMax = 5'h00;
      3'h1:    divMax = 5'h01;
      3'h2:    divMax = 5'h03;
      3'h3:    divMax = 5'h07;
      default: divMax = 5'h0F;
    endcase
    acc     = psel && penable;
    wr      = acc && pwrite;
    protHit = wr && (paddr == ADDR_STANDBY || paddr == ADDR_GEAR
                     || paddr == ADDR_NOISE);
    wrOk    = !cur_r.protect;
    canWake = '0;
    unique case (cur_r.st)
      ST_LIGHT: canWake = {SRC_NUM{1'b1}};
      ST_DEEP:  canWake = (SRC_NUM)'(6'h0F);
      ST_STOP:  canWake = (SRC_NUM)'(6'h03);
      default:  canWake = '0;
    endcase
    svc = nmiReq || |(okLvl & canWake);
    res = |(irqReq & canWake & (SRC_NUM)'(6'h0F));
    // ==========================================================================
    // Wake qualification
    // Sources held in the entry window do not count as new requests
    svcNew = nmiReq || |(okLvl & freshReq & canWake);
    resNew = |(freshReq & canWake & (SRC_NUM)'(6'h0F));
  end
  // ==========================================================================
  // Next state
  always_comb begin
    cur_nxt         = cur_r;
    cur_nxt.pready  = 1'b0;
    cur_nxt.pslverr = 1'b0;
    cur_nxt.viol    = 1'b0;
    cur_nxt.wakeSvc = 1'b0;
    cur_nxt.wakeRes = 1'b0;
    gearWr          = 1'b0;
    // ==========================================================================
    // APB single wait state: answer in the second cycle of the access phase
    if (acc && !cur_r.pready) begin
      cur_nxt.pready = 1'b1;
      cur_nxt.prdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          ADDR_STANDBY: cur_nxt.prdata[5:0] = {cur_r.warmupSel, cur_r.haltSel, 2'h0};
          ADDR_GEAR:    cur_nxt.prdata[2:0] = cur_r.gearSel;
          ADDR_NOISE:   cur_nxt.prdata[7:0] = {cur_r.protect, 4'h0, cur_r.ext_clock_in,
                                               cur_r.hfDrv, cur_r.lfDrv};
          ADDR_KEY_ONE, ADDR_KEY_TWO, ADDR_PROT_EXT: cur_nxt.prdata = '0;
          ADDR_IDLE_EN: cur_nxt.prdata[4:0] = cur_r.idleEn;
          ADDR_STATUS:  cur_nxt.prdata[5:0] = {cur_r.gearPend, cur_r.gearAct,
                                               cur_r.st == ST_RUN, cur_r.protect};
          default:      cur_nxt.pslverr = 1'b1;
        endcase
      end else begin
        if (protHit && !wrOk) begin
          cur_nxt.viol = 1'b1;
        end
        if (wrOk) begin
          unique case (paddr)
            ADDR_STANDBY: begin
              cur_nxt.warmupSel = pwdata[WARMUP_LSB +: 2];
              cur_nxt.haltSel   = pwdata[HALTM_LSB +: 2];
            end
            ADDR_GEAR: begin
              if (pwdata[2:0] <= 3'h4) begin
                cur_nxt.gearSel  = pwdata[2:0];
                cur_nxt.gearPend = 1'b1;
                cur_nxt.wuCnt    = '0;
                gearWr           = 1'b1;
              end
            end
            ADDR_NOISE: begin
              cur_nxt.ext_clock_in = pwdata[EXT_CLOCK_IN_BIT];
              cur_nxt.hfDrv = pwdata[HFDRV_BIT];
              cur_nxt.lfDrv = pwdata[LFDRV_BIT];
            end
            default: ;
          endcase
        end
        if (paddr == ADDR_IDLE_EN) begin
          cur_nxt.idleEn = pwdata[4:0];
        end
        if (paddr == ADDR_PROT_EXT) begin
          cur_nxt.pslverr = 1'b0;
        end
        if (!(paddr inside {ADDR_STANDBY, ADDR_GEAR, ADDR_NOISE, ADDR_KEY_ONE,
                            ADDR_KEY_TWO, ADDR_IDLE_EN, ADDR_STATUS, ADDR_PROT_EXT})) begin
          cur_nxt.pslverr = 1'b1;
        end
        // ==========================================================================
        // Double-key sequence; any other write aborts
        cur_nxt.keySt = KS_IDLE;
        unique case (cur_r.keySt)
          KS_IDLE: begin
            if (paddr == ADDR_KEY_ONE && pwdata[7:0] == KEY_A) begin
              cur_nxt.keySt    = KS_K1A;
              cur_nxt.keyFirst = 1'b0;
            end else if (paddr == ADDR_KEY_ONE && pwdata[7:0] == KEY_B && cur_r.keyFirst) begin
              cur_nxt.keySt = KS_K1B;
            end else begin
              cur_nxt.keyFirst = 1'b0;
            end
          end
          KS_K1A: begin
            if (paddr == ADDR_KEY_TWO && pwdata[7:0] == KEY_B) begin
              cur_nxt.keyFirst = 1'b1;
            end
          end
          KS_K1B: begin
            cur_nxt.keyFirst = 1'b0;
            if (paddr == ADDR_KEY_TWO && pwdata[7:0] == KEY_A) begin
              cur_nxt.protect = !cur_r.protect;
            end
          end
        endcase
      end
    end
    if (protExtWrite && cur_r.protect) begin
      cur_nxt.viol = 1'b1;
    end
    // ==========================================================================
    // Gear warm-up and fast-clock divider
    // A gear write in the same cycle restarts the count and wins
    if (cur_r.gearPend && !gearWr) begin
      if (cur_r.wuCnt + 17'h1 >= wuLen) begin
        cur_nxt.gearAct  = cur_r.gearSel;
        cur_nxt.gearPend = 1'b0;
        cur_nxt.divCnt   = '0;
      end else begin
        cur_nxt.wuCnt = cur_r.wuCnt + 17'h1;
      end
    end
    if (cur_r.divCnt >= divMax) begin
      cur_nxt.divCnt = '0;
      cur_nxt.fastEn = 1'b1;
    end else begin
      cur_nxt.divCnt = cur_r.divCnt + 5'h1;
      cur_nxt.fastEn = 1'b0;
    end
    // ==========================================================================
    // Standby controller
    unique case (cur_r.st)
      ST_RUN: begin
        if (haltReq) begin
          cur_nxt.entCnt = '0;
          // Entry drops any stale pending state
          cur_nxt.heldPend = 1'b0;
          cur_nxt.heldSrc  = '0;
          unique case (cur_r.haltSel)
            HALT_LIGHT: cur_nxt.st = ST_LIGHT;
            HALT_DEEP:  cur_nxt.st = ST_DEEP;
            HALT_STOP:  cur_nxt.st = ST_STOP;
            default:    cur_nxt.st = ST_RUN;
          endcase
        end
      end
      ST_LIGHT: begin
        if (svc) begin
          cur_nxt.st = ST_RUN;
          cur_nxt.wakeSvc = 1'b1;
        end else if (res) begin
          cur_nxt.st = ST_RUN;
          cur_nxt.wakeRes = 1'b1;
        end
      end
      ST_DEEP, ST_STOP: begin
        if (cur_r.entCnt < 2'(HOLD_WIN_CYC)) begin
          if (cur_r.fastEn) begin
            cur_nxt.entCnt = cur_r.entCnt + 2'h1;
          end
          // Requests in the entry window only latch as pending
          if (svc) begin
            cur_nxt.heldPend = 1'b1;
          end
          cur_nxt.heldSrc = cur_r.heldSrc | (irqReq & canWake);
        end else begin
          // A held source that drops may wake again later
          cur_nxt.heldSrc = cur_r.heldSrc & irqReq;
          if (svcNew || resNew) begin
            cur_nxt.st       = ST_RUN;
            cur_nxt.heldPend = 1'b0;
            cur_nxt.heldSrc  = '0;
            cur_nxt.wakeSvc  = svcNew || cur_r.heldPend;
            cur_nxt.wakeRes  = !(svcNew || cur_r.heldPend);
          end
        end
      end
    endcase
  end
  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_r           <= '0;
      cur_r.gearSel   <= GEAR_RST;
      cur_r.gearAct   <= GEAR_RST;
      cur_r.warmupSel <= WARMUP_RST;
      cur_r.haltSel   <= HALTM_RST;
      cur_r.hfDrv     <= 1'b1;
      cur_r.lfDrv     <= 1'b1;
      cur_r.idleEn    <= IDLE_EN_RST;
      cur_r.keySt     <= KS_IDLE;
      cur_r.st        <= ST_RUN;
    end else begin
      cur_r <= cur_nxt;
    end
  end
  // ==========================================================================
  // Registered outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {fastClkEn, cpuClkEn, periClkEn, rtcClkEn, hfOscEn} <= 5'h1F;
      idleRunEn  <= 5'h1F;
      hfOscDrive <= 1'b1;
      lfOscDrive <= 1'b1;
      extClockIn <= 1'b0;
      oscOutPin  <= 1'b0;
      portHold   <= 1'b0;
    end else begin
      fastClkEn  <= cur_nxt.fastEn && cur_nxt.st != ST_STOP && cur_nxt.st != ST_DEEP;
      cpuClkEn   <= cur_nxt.st == ST_RUN;
      periClkEn  <= cur_nxt.st inside {ST_RUN, ST_LIGHT};
      idleRunEn  <= (cur_nxt.st == ST_LIGHT) ? cur_nxt.idleEn
                  : (cur_nxt.st == ST_RUN) ? 5'h1F : 5'h00;
      rtcClkEn   <= cur_nxt.st != ST_STOP;
      hfOscEn    <= cur_nxt.st != ST_STOP && !cur_nxt.ext_clock_in;
      hfOscDrive <= cur_nxt.hfDrv;
      lfOscDrive <= cur_nxt.lfDrv;
      extClockIn <= cur_nxt.ext_clock_in;
      oscOutPin  <= cur_nxt.ext_clock_in;
      portHold   <= cur_nxt.st == ST_LIGHT;
    end
  end
  assign prdata      = cur_r.prdata;
  assign pready      = cur_r.pready;
  assign pslverr     = cur_r.pslverr;
  assign wakeService = cur_r.wakeSvc;
  assign wakeResume  = cur_r.wakeRes;
  assign protViolIrq = cur_r.viol;
endmodule : cgs_clock_standby
`default_nettype wire

// ### verification/cgs_clock_standby_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cgs_clock_standby_sva
  import cgs_pkg::*;
(
  input wire logic       ref_clk,      // Clock
  input wire logic       rst,          // Reset
  input wire logic       psel,         // Select
  input wire logic       penable,      // Enable
  input wire logic       pready,       // Ready
  input wire logic       pslverr,      // Error
  input wire logic       haltReq,      // Halt
  input wire logic       nmiReq,       // NMI
  input wire logic       protExtWrite, // Ext write
  input wire logic       fastClkEn,    // Fast pulse
  input wire logic       cpuClkEn,     // CPU gate
  input wire logic       periClkEn,    // Peri gate
  input wire logic [4:0] idleRunEn,    // Run gates
  input wire logic       rtcClkEn,     // RTC gate
  input wire logic       hfOscEn,      // Osc run
  input wire logic       extClockIn,   // Ext mode
  input wire logic       oscOutPin,    // Out pin
  input wire logic       portHold,     // Pin hold
  input wire logic       wakeService,  // Wake svc
  input wire logic       wakeResume,   // Wake res
  input wire logic       protViolIrq   // Violation
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ACCESS_ANSWER: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_VIOL_CAUSE: assert property (protViolIrq |-> pready || $past(protExtWrite))
    else $error("violation without write");
  AST_EXT_PIN: assert property (extClockIn |-> oscOutPin && !hfOscEn)
    else $error("external clock pin wrong");
  AST_STOP_ALL: assert property (!rtcClkEn |-> !hfOscEn && !cpuClkEn && !fastClkEn)
    else $error("stop left a clock running");
  AST_DEEP_GATED: assert property (!periClkEn |-> !fastClkEn && idleRunEn == 5'h00)
    else $error("gated clock still running");
  AST_LIGHT_HOLD: assert property (portHold |-> !cpuClkEn && periClkEn)
    else $error("light idle gates wrong");
  AST_RUN_GATES: assert property (cpuClkEn |-> rtcClkEn && idleRunEn == 5'h1F && !portHold)
    else $error("run gates wrong");
  AST_HALT_ENTER: assert property (haltReq && cpuClkEn |-> ##[1:4] !cpuClkEn)
    else $error("halt not entered");
  AST_NMI_WAKE: assert property (nmiReq && portHold |-> ##[1:4] wakeService)
    else $error("nmi did not wake");
  AST_WAKE_ONE: assert property (wakeService |=> !wakeService && !wakeResume)
    else $error("wake pulse repeated");
  cover property (portHold);
  cover property (wakeResume);
  cover property (protViolIrq);
  cover property (pslverr);
endmodule : cgs_clock_standby_sva
bind cgs_clock_standby cgs_clock_standby_sva u_sva (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .haltReq(haltReq), .nmiReq(nmiReq), .protExtWrite(protExtWrite),
  .fastClkEn(fastClkEn), .cpuClkEn(cpuClkEn), .periClkEn(periClkEn),
  .idleRunEn(idleRunEn), .rtcClkEn(rtcClkEn), .hfOscEn(hfOscEn),
  .extClockIn(extClockIn), .oscOutPin(oscOutPin), .portHold(portHold),
  .wakeService(wakeService), .wakeResume(wakeResume), .protViolIrq(protViolIrq));
`default_nettype wire

// ### verification/cgs_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module cgs_irq_model
  import cgs_pkg::*;
(
  input  wire logic        ref_clk,     // Clock
  input  wire logic        rst,         // Reset
  input  wire logic        fire,        // Raise request
  input  wire logic [2:0]  fireSrc,     // Source
  input  wire logic [2:0]  fireLvl,     // Level
  input  wire logic        fireNmi,     // Raise NMI
  input  wire logic        wakeService, // Serviced
  output logic [5:0]       irqReq,      // Requests
  output logic [17:0]      irqLevel,    // Levels
  output logic             nmiReq       // NMI
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqReq   <= 6'h00;
      irqLevel <= 18'h00000;
      nmiReq   <= 1'b0;
    end else if (fire) begin
      if (fireNmi) nmiReq <= 1'b1;
      else begin
        irqReq[fireSrc]              <= 1'b1;
        irqLevel[3*int'(fireSrc)+:3] <= fireLvl;
      end
    end else if (wakeService) begin
      // Flags stay set on a resume
      irqReq <= 6'h00;
      nmiReq <= 1'b0;
    end
  end
endmodule : cgs_irq_model
`default_nettype wire

// ### verification/clock_gear_standby_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_gear_standby_control_bench;
  import cgs_pkg::*;
  logic        ref_clk, rst, psel, penable, pwrite, haltReq, protExtWrite, fire, fireNmi;
  logic        pready, pslverr, fastClkEn, cpuClkEn, periClkEn, rtcClkEn, hfOscEn, nmiReq;
  logic        hfOscDrive, lfOscDrive, extClockIn, oscOutPin, portHold, e, v;
  logic        wakeService, wakeResume, protViolIrq, prot;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] mdl [8];
  logic [2:0]  irqMaskLevel, fireSrc, fireLvl;
  logic [4:0]  idleRunEn;
  logic [5:0]  irqReq;
  logic [17:0] irqLevel;
  int          err_count = 0, compares = 0, nS = 0, nR = 0, nV = 0, ks, p, gact;
  cgs_clock_standby #(.WU8(16), .WU14(24), .WU16(32)) u_cgs_clock_standby (.*);
  cgs_irq_model u_cgs_irq_model (.*);
  // ==========
  // Clock, pulse counters, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wakeService === 1'b1) nS++;
    if (wakeResume === 1'b1) nR++;
    if (protViolIrq === 1'b1) nV++;
  end
  initial begin
    #3000000;
    err_count++;
    test_done();
  end
  // ==========
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    v = protViolIrq;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20) err_count++;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic blk;
    blk = prot && (a == ADDR_STANDBY || a == ADDR_GEAR || a == ADDR_NOISE);
    apb(1'b1, a, d);
    chk("viol", v, blk);
    if (!blk) begin
      if (a == ADDR_STANDBY) mdl[0] = d & 32'h3C;
      if (a == ADDR_GEAR && d[2:0] <= 3'h4) mdl[1] = d & 32'h7;
      if (a == ADDR_NOISE) mdl[2] = d & 32'h7;
      if (a == ADDR_IDLE_EN) mdl[5] = d & 32'h1F;
    end
    if (a == ADDR_KEY_ONE && d[7:0] == KEY_A) ks = 1;
    else if (ks == 1 && a == ADDR_KEY_TWO && d[7:0] == KEY_B) ks = 2;
    else if (ks == 2 && a == ADDR_KEY_ONE && d[7:0] == KEY_B) ks = 3;
    else if (ks == 3 && a == ADDR_KEY_TWO && d[7:0] == KEY_A) begin
      ks = 0;
      prot = !prot;
    end else ks = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("rdata", r, x);
  endtask : rd
  task automatic do_rst;
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    mdl[0] = 32'(WARMUP_RST) << WARMUP_LSB | 32'(HALTM_RST) << HALTM_LSB;
    mdl[1] = 32'(GEAR_RST);
    mdl[2] = 32'h3;
    mdl[5] = 32'h0;
    prot = 1'b0;
    ks = 0;
    @(posedge ref_clk);
  endtask : do_rst
  task automatic per;
    int n;
    n = 0;
    p = 0;
    while (fastClkEn !== 1'b1 && n < 64) begin
      @(posedge ref_clk);
      n++;
    end
    do begin
      @(posedge ref_clk);
      p++;
    end while (fastClkEn !== 1'b1 && p < 64);
  endtask : per
  task automatic trial(input logic [1:0] m, input int pre, input int src, input logic [2:0] lvl,
                       input int es, input int er);
    int s0, r0;
    do_rst();
    rd(ADDR_NOISE, 32'h3);
    wr(ADDR_IDLE_EN, $urandom % 16);
    wr(ADDR_STANDBY, {26'h0, WU_8, m, 2'b00});
    haltReq <= 1'b1;
    @(posedge ref_clk);
    haltReq <= 1'b0;
    repeat (pre) @(posedge ref_clk);
    chk("gates", {cpuClkEn, portHold, rtcClkEn, idleRunEn}, {1'b0, m == HALT_LIGHT,
        m != HALT_STOP, m == HALT_LIGHT ? mdl[5][4:0] : 5'h0});
    s0 = nS;
    r0 = nR;
    fireSrc <= 3'(src);
    fireLvl <= lvl;
    fireNmi <= (src == 7);
    fire    <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (150) @(posedge ref_clk);
    chk("service", nS - s0, es);
    chk("resume", nR - r0, er);
  endtask : trial
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // ==========
  // Scenarios
  initial begin
    {rst, psel, penable, pwrite, haltReq, protExtWrite, fire, fireNmi} = 8'h80;
    {paddr, pwdata, fireSrc, fireLvl} = '0;
    irqMaskLevel = 3'h3;
    void'($urandom(32'h8c77));
    do_rst();
    rd(ADDR_STANDBY, mdl[0]);
    rd(ADDR_GEAR, mdl[1]);
    rd(ADDR_NOISE, 32'h3);
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", e, 1'b1);
    wr(ADDR_NOISE, 32'h4);
    chk("extPin", {extClockIn, oscOutPin, hfOscEn}, 3'b110);
    wr(ADDR_NOISE, 32'h0);
    chk("drive", {hfOscDrive, lfOscDrive}, 2'b00);
    wr(ADDR_NOISE, 32'h3);
    gact = 4;
    for (int g = 0; g < 5; g++) begin
      wr(ADDR_STANDBY, {26'h0, 2'(g % 3 + 1), HALT_LIGHT, 2'b00});
      wr(ADDR_GEAR, 32'(g));
      rd(ADDR_STATUS, 32'h22 | 32'(gact) << 2);
      wr(ADDR_PROT_EXT, 32'h0);
      // Two reads straddle the last warm-up cycle (16, 24 or 32 here)
      repeat (8 * (g % 3) + 1) @(posedge ref_clk);
      rd(ADDR_STATUS, 32'h22 | 32'(gact) << 2);
      rd(ADDR_STATUS, 32'(g) << 2 | 32'h2);
      repeat (40) @(posedge ref_clk);
      per();
      chk("period", p, 1 << g);
      rd(ADDR_STATUS, 32'(g) << 2 | 32'h2);
      gact = g;
    end
    wr(ADDR_GEAR, 32'h5);
    rd(ADDR_GEAR, mdl[1]);
    wr(ADDR_KEY_ONE, 32'(KEY_A));
    wr(ADDR_IDLE_EN, $urandom % 32);
    wr(ADDR_KEY_TWO, 32'(KEY_B));
    wr(ADDR_KEY_ONE, 32'(KEY_B));
    wr(ADDR_KEY_TWO, 32'(KEY_A));
    rd(ADDR_NOISE, 32'h3);
    for (int i = 0; i < 4; i++) wr(i[0] ? ADDR_KEY_TWO : ADDR_KEY_ONE,
                                   32'(i == 0 || i == 3 ? KEY_A : KEY_B));
    rd(ADDR_NOISE, 32'h83);
    wr(ADDR_NOISE, 32'h0);
    wr(ADDR_GEAR, 32'h1);
    rd(ADDR_NOISE, 32'h83);
    rd(ADDR_GEAR, mdl[1]);
    rd(ADDR_IDLE_EN, mdl[5]);
    p = nV;
    protExtWrite <= 1'b1;
    @(posedge ref_clk);
    protExtWrite <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("extViol", nV - p, 1);
    trial(HALT_LIGHT, 3, SRC_EXT, 3'(3 + $urandom % 5), 1, 0);
    trial(HALT_LIGHT, 3, SRC_PERI, 3'h1, 0, 0);
    trial(HALT_LIGHT, 3, SRC_WDT, 3'h5, 1, 0);
    trial(HALT_DEEP, 100, SRC_WDT, 3'h5, 0, 0);
    trial(HALT_DEEP, 100, SRC_KEY, 3'h1, 0, 1);
    trial(HALT_DEEP, 100, SRC_CLOCK, 3'h6, 1, 0);
    trial(HALT_STOP, 100, SRC_ALARM, 3'h6, 0, 0);
    trial(HALT_STOP, 100, 7, 3'h0, 1, 0);
    trial(HALT_LIGHT, 3, 7, 3'h0, 1, 0);
    trial(HALT_DEEP, 2, SRC_EXT, 3'h5, 0, 0);
    test_done();
  end
endmodule : clock_gear_standby_control_bench
`default_nettype wire
